// ==== pmld_map.svh ====
// register indices, field positions, reset values and thresholds of the mode and diagnostic registers
// Notes on behaviour
// - four read-only peak polarity bits at 14:11; 1 negative, 0 positive
// - negative peak hints at a short, positive peak hints at an open
// - operation-mode bit 6 resets from bootstrap; 1 autonomous, 0 managed
// - operation-mode bit reads zero after any read or write of it
// - managed operation entered only at reset when bootstrap sampled
// - sleep-select bit 1 (reset 1): sleep after negotiation, else standby
// - sleep code-groups sent only while permit bit 0 (reset 0) set
// - sleep-request bit 1 starts sleep code-group transmission; 0 normal operation
// - force-normal bit 0 forces normal; self-clears only on standby-to-normal
// - 9-bit read-only ratio at 8:0, ten times decibels, unsigned
// - quality status 9:8: 00 none, 01 poor, 10 good, 11 excellent
// - quality value above 70 excellent, 40 to 70 good, below 40 poor
`ifndef PMLD_MAP_SVH
`define PMLD_MAP_SVH

// register indices; byte address is four times the index
`define PMLD_IDX_PEAK      10'h18A
`define PMLD_IDX_AUTO      10'h18B
`define PMLD_IDX_PWR_CMD   10'h18C
`define PMLD_IDX_SNR       10'h197
`define PMLD_IDX_SQI       10'h198

`define PMLD_ADDR_W        12

// field positions
`define PMLD_PEAK_LSB      4'hB
`define PMLD_AUTO_CMD_BIT  6
`define PMLD_AUTO_RSV_LSB  2
`define PMLD_SLEEP_SEL_BIT 1
`define PMLD_PERMIT_BIT    0
`define PMLD_SLEEP_REQ_BIT 1
`define PMLD_FORCE_NRM_BIT 0
`define PMLD_SQS_LSB       8

// reset values
`define PMLD_AUTO_RSV_RST  4'h6
`define PMLD_SLEEP_SEL_RST 1'h1
`define PMLD_PERMIT_RST    1'h0
`define PMLD_MODE_RST      1'h0

// quality thresholds
`define PMLD_SQI_EXCELLENT 8'h46
`define PMLD_SQI_GOOD      8'h28

`endif

// ==== pmld_pkg.sv ====
// types shared by the mode and diagnostic register block
package pmld_pkg;

  typedef enum logic [1:0] {
    PMLD_STRAP_FILL1 = 2'b00,
    PMLD_STRAP_FILL2 = 2'b01,
    PMLD_STRAP_FILL3 = 2'b10,
    PMLD_STRAP_DONE  = 2'b11
  } pmld_strap_t;

  typedef enum logic [1:0] {
    PMLD_SQS_NONE      = 2'b00,
    PMLD_SQS_POOR      = 2'b01,
    PMLD_SQS_GOOD      = 2'b10,
    PMLD_SQS_EXCELLENT = 2'b11
  } pmld_sqs_t;

  typedef struct packed {
    logic [8:0] snrValue;
    logic [7:0] sqiValue;
    pmld_sqs_t  sqiStatus;
  } pmld_quality_t;

  typedef struct packed {
    logic        strapSync1;
    logic        strapSync2;
    pmld_strap_t strapPhase;
    logic        autonomousMode;
    logic        autoCmd;
    logic [3:0]  autoReserved;
    logic        sleepSelect;
    logic        codegroupPermit;
    logic        sleepRequest;
    logic        forceNormal;
    logic [3:0]  peakPolarity;
    logic        enterSleep;
    logic        enterStandby;
    logic [31:0] prdata;
  } pmld_state_t;

endpackage

// ==== pmld_quality.sv ====
// signal quality and signal-to-noise result capture with status classification
`timescale 1ns/10ps
`default_nettype none
`include "pmld_map.svh"

module pmld_quality
  import pmld_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       linkUp,
  input  wire logic [8:0] snrRaw,
  input  wire logic [7:0] sqiRaw,
  output logic      [8:0] snrValue,
  output logic      [7:0] sqiValue,
  output logic      [1:0] sqiStatus
);

  pmld_quality_t state;
  pmld_quality_t next_state;

  always_comb begin
    next_state          = state;
    // raw ratio passes unfiltered; software must discard it without a link
    next_state.snrValue = snrRaw;
    next_state.sqiValue = sqiRaw;
    // status derived from the same value so the two fields never disagree
    if (!linkUp) begin
      next_state.sqiStatus = PMLD_SQS_NONE;
    end else if (sqiRaw > `PMLD_SQI_EXCELLENT) begin
      next_state.sqiStatus = PMLD_SQS_EXCELLENT;
    end else if (sqiRaw >= `PMLD_SQI_GOOD) begin
      next_state.sqiStatus = PMLD_SQS_GOOD;
    end else begin
      next_state.sqiStatus = PMLD_SQS_POOR;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= '{snrValue: 9'h000, sqiValue: 8'h00, sqiStatus: PMLD_SQS_NONE};
    end else begin
      state <= next_state;
    end
  end

  assign snrValue  = state.snrValue;
  assign sqiValue  = state.sqiValue;
  assign sqiStatus = state.sqiStatus;

endmodule
`default_nettype wire

// ==== pmld_regs.sv ====
// power mode, autonomous operation and link diagnostic registers behind an apb slave
//
// The APB slave port was left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "pmld_map.svh"

module pmld_regs
  import pmld_pkg::*;
(
  input  wire logic                    clk,
  input  wire logic                    rst,
  // apb slave
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [`PMLD_ADDR_W-1:0] paddr,
  input  wire logic [31:0]             pwdata,
  output logic      [31:0]             prdata,
  output logic                         pready,
  output logic                         pslverr,
  // bootstrap pin, asynchronous to clk
  input  wire logic                    strapAutonomous,
  // diagnostic results from the cable test and receiver, same clock
  input  wire logic [3:0]              peakNegative,
  input  wire logic                    linkUp,
  input  wire logic [8:0]              snrRaw,
  input  wire logic [7:0]              sqiRaw,
  // power state machine events, same clock, one-cycle pulses
  input  wire logic                    sleepNegotiated,
  input  wire logic                    standbyToNormal,
  // commands and modes towards the power state machine and transmitter
  output logic                         autonomousMode,
  output logic                         sleepCodegroupPermit,
  output logic                         sendSleepCodegroups,
  output logic                         sleepRequest,
  output logic                         forceNormal,
  output logic                         enterSleep,
  output logic                         enterStandby
);

  pmld_state_t state;
  pmld_state_t next_state;

  logic [8:0] snrValue;
  logic [7:0] sqiValue;
  logic [1:0] sqiStatus;

  pmld_quality i_pmld_quality (
    .clk       (clk),
    .rst       (rst),
    .linkUp    (linkUp),
    .snrRaw    (snrRaw),
    .sqiRaw    (sqiRaw),
    .snrValue  (snrValue),
    .sqiValue  (sqiValue),
    .sqiStatus (sqiStatus)
  );

  // address decode
  logic                    aligned;
  logic [9:0]              regIndex;
  logic                    hitPeak;
  logic                    hitAuto;
  logic                    hitPwrCmd;
  logic                    hitSnr;
  logic                    hitSqi;
  logic                    mapped;
  logic                    setupPhase;
  logic                    accessPhase;
  logic                    writeTaken;
  logic                    readTaken;

  assign aligned     = (paddr[1:0] == 2'h0);
  assign regIndex    = paddr[`PMLD_ADDR_W-1:2];
  assign hitPeak     = aligned && (regIndex == `PMLD_IDX_PEAK);
  assign hitAuto     = aligned && (regIndex == `PMLD_IDX_AUTO);
  assign hitPwrCmd   = aligned && (regIndex == `PMLD_IDX_PWR_CMD);
  assign hitSnr      = aligned && (regIndex == `PMLD_IDX_SNR);
  assign hitSqi      = aligned && (regIndex == `PMLD_IDX_SQI);
  assign mapped      = hitPeak || hitAuto || hitPwrCmd || hitSnr || hitSqi;
  assign setupPhase  = psel && !penable;
  assign accessPhase = psel && penable;
  assign writeTaken  = accessPhase && pwrite && mapped;
  assign readTaken   = accessPhase && !pwrite && mapped;

  // read data assembly; unlisted bits stay zero
  logic [15:0] readWord;

  always_comb begin
    readWord = 16'h0000;
    unique case (1'b1)
      hitPeak: begin
        readWord[`PMLD_PEAK_LSB +: 4] = state.peakPolarity;
      end
      hitAuto: begin
        readWord[`PMLD_AUTO_CMD_BIT]        = state.autoCmd;
        readWord[`PMLD_AUTO_RSV_LSB +: 4]   = state.autoReserved;
        readWord[`PMLD_SLEEP_SEL_BIT]       = state.sleepSelect;
        readWord[`PMLD_PERMIT_BIT]          = state.codegroupPermit;
      end
      hitPwrCmd: begin
        readWord[`PMLD_SLEEP_REQ_BIT] = state.sleepRequest;
        readWord[`PMLD_FORCE_NRM_BIT] = state.forceNormal;
      end
      hitSnr: begin
        readWord[8:0] = snrValue;
      end
      hitSqi: begin
        readWord[`PMLD_SQS_LSB +: 2] = sqiStatus;
        readWord[7:0]                = sqiValue;
      end
      default: begin
        readWord = 16'h0000;
      end
    endcase
  end

  always_comb begin
    next_state = state;

    // strap path: first flop feeds only the second
    next_state.strapSync1 = strapAutonomous;
    next_state.strapSync2 = state.strapSync1;

    // mode is fixed once, three edges after reset release; the synchroniser
    // flops come out of reset at zero, so the strap needs two edges to cross
    unique case (state.strapPhase)
      PMLD_STRAP_FILL1: begin
        next_state.strapPhase = PMLD_STRAP_FILL2;
      end
      PMLD_STRAP_FILL2: begin
        next_state.strapPhase = PMLD_STRAP_FILL3;
      end
      PMLD_STRAP_FILL3: begin
        next_state.strapPhase     = PMLD_STRAP_DONE;
        next_state.autonomousMode = state.strapSync2;
        next_state.autoCmd        = state.strapSync2;
      end
      PMLD_STRAP_DONE: begin
        next_state.strapPhase = PMLD_STRAP_DONE;
      end
    endcase

    // diagnostics follow the cable test; polarity alone, validity is for software
    next_state.peakPolarity = peakNegative;

    // read data captured in setup so prdata is a flop during access
    if (setupPhase) begin
      next_state.prdata = {16'h0000, readWord};
    end

    // any access of the autonomous register consumes the one-time bit;
    // a write can never select managed or autonomous operation afterwards
    // capture wins over an access in the same cycle
    if ((readTaken || writeTaken) && hitAuto && (state.strapPhase == PMLD_STRAP_DONE)) begin
      next_state.autoCmd = 1'b0;
    end

    if (writeTaken && hitAuto) begin
      next_state.autoReserved    = pwdata[`PMLD_AUTO_RSV_LSB +: 4];
      next_state.sleepSelect     = pwdata[`PMLD_SLEEP_SEL_BIT];
      next_state.codegroupPermit = pwdata[`PMLD_PERMIT_BIT];
    end

    if (writeTaken && hitPwrCmd) begin
      next_state.sleepRequest = pwdata[`PMLD_SLEEP_REQ_BIT];
      next_state.forceNormal  = pwdata[`PMLD_FORCE_NRM_BIT];
    end

    // self clear only on the standby to normal move; a write of one in the
    // same cycle wins so the request is not lost
    if (standbyToNormal && !(writeTaken && hitPwrCmd && pwdata[`PMLD_FORCE_NRM_BIT])) begin
      next_state.forceNormal = 1'b0;
    end

    // negotiation outcome steers the power state machine
    next_state.enterSleep   = sleepNegotiated && state.sleepSelect;
    next_state.enterStandby = sleepNegotiated && !state.sleepSelect;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= '{
        strapSync1:      1'b0,
        strapSync2:      1'b0,
        strapPhase:      PMLD_STRAP_FILL1,
        autonomousMode:  `PMLD_MODE_RST,
        autoCmd:         `PMLD_MODE_RST,
        autoReserved:    `PMLD_AUTO_RSV_RST,
        sleepSelect:     `PMLD_SLEEP_SEL_RST,
        codegroupPermit: `PMLD_PERMIT_RST,
        sleepRequest:    1'b0,
        forceNormal:     1'b0,
        peakPolarity:    4'h0,
        enterSleep:      1'b0,
        enterStandby:    1'b0,
        prdata:          32'h0000_0000
      };
    end else begin
      state <= next_state;
    end
  end

  // zero wait state slave; unmapped or misaligned access answers with an error
  assign pready  = 1'b1;
  assign pslverr = accessPhase && !mapped;
  assign prdata  = state.prdata;

  assign autonomousMode       = state.autonomousMode;
  assign sleepCodegroupPermit = state.codegroupPermit;
  // code-groups need both the request and the permit
  assign sendSleepCodegroups  = state.sleepRequest && state.codegroupPermit;
  assign sleepRequest         = state.sleepRequest;
  assign forceNormal          = state.forceNormal;
  assign enterSleep           = state.enterSleep;
  assign enterStandby         = state.enterStandby;

endmodule
`default_nettype wire

// ==== pmld_regs_asserts.sv ====
// concurrent checks on the pins of the mode and diagnostic register block
`timescale 1ns/10ps
`default_nettype none
`include "pmld_map.svh"

module pmld_regs_asserts
  import pmld_pkg::*;
(
  input wire logic                    clk,
  input wire logic                    rst,
  input wire logic                    psel,
  input wire logic                    penable,
  input wire logic                    pwrite,
  input wire logic [`PMLD_ADDR_W-1:0] paddr,
  input wire logic [31:0]             pwdata,
  input wire logic [31:0]             prdata,
  input wire logic                    pready,
  input wire logic                    pslverr,
  input wire logic                    strapAutonomous,
  input wire logic [3:0]              peakNegative,
  input wire logic                    linkUp,
  input wire logic [8:0]              snrRaw,
  input wire logic [7:0]              sqiRaw,
  input wire logic                    sleepNegotiated,
  input wire logic                    standbyToNormal,
  input wire logic                    autonomousMode,
  input wire logic                    sleepCodegroupPermit,
  input wire logic                    sendSleepCodegroups,
  input wire logic                    sleepRequest,
  input wire logic                    forceNormal,
  input wire logic                    enterSleep,
  input wire logic                    enterStandby
);
  logic [2:0] edges;
  logic [1:0] sqsExp;
  logic       pwrCmdWr;
  logic       setup;

  // saturating count of edges since reset; the strap is settled by the fourth
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      edges <= 3'h0;
    end else if (edges != 3'h4) begin
      edges <= edges + 3'h1;
    end
  end

  assign setup  = psel && !penable;
  assign pwrCmdWr = psel && penable && pwrite && (paddr == {`PMLD_IDX_PWR_CMD, 2'h0});
  assign sqsExp = !linkUp ? 2'h0 : (sqiRaw > `PMLD_SQI_EXCELLENT) ? 2'h3 :
                  (sqiRaw >= `PMLD_SQI_GOOD) ? 2'h2 : 2'h1;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_codegroup_gate: assert property (sendSleepCodegroups == (sleepRequest && sleepCodegroupPermit))
    else $error("codegroup send not gated by request and permit");
  a_event_pulse: assert property (sleepNegotiated |=> enterSleep != enterStandby)
    else $error("negotiation not followed by exactly one of sleep or standby");
  a_event_quiet: assert property (!sleepNegotiated |=> !enterSleep && !enterStandby)
    else $error("sleep or standby without negotiation");
  a_force_hold: assert property (forceNormal && !standbyToNormal && !pwrCmdWr |=> forceNormal)
    else $error("force-normal dropped without standby to normal");
  a_pwr_cmd_write: assert property (pwrCmdWr |=> forceNormal == $past(pwdata[0]) && sleepRequest == $past(pwdata[1]))
    else $error("power mode write not applied");
  a_mode_strap: assert property (edges == 3'h4 |-> autonomousMode == strapAutonomous)
    else $error("mode does not match strap");
  a_mode_fixed: assert property (edges == 3'h4 |=> $stable(autonomousMode))
    else $error("mode changed after strap capture");
  a_peak_read: assert property (setup && paddr == {`PMLD_IDX_PEAK, 2'h0} |=> prdata == {17'h0, $past(peakNegative, 2), 11'h0})
    else $error("peak polarity read wrong");
  a_sqi_read: assert property (setup && paddr == {`PMLD_IDX_SQI, 2'h0} |=> prdata == {22'h0, $past(sqsExp, 2), $past(sqiRaw, 2)})
    else $error("quality read wrong");
endmodule

bind pmld_regs pmld_regs_asserts i_pmld_regs_asserts (.*);

`default_nettype wire

// ==== pmld_regs_test.sv ====
// self-checking bench for the mode and diagnostic register block
`timescale 1ns/10ps
`default_nettype none
`include "pmld_map.svh"

module pmld_regs_test
  import pmld_pkg::*;
;
  logic        clk, rst, psel, penable, pwrite, strapAutonomous, linkUp, rerr;
  logic        sleepNegotiated, standbyToNormal, pready, pslverr, autonomousMode;
  logic        sleepCodegroupPermit, sendSleepCodegroups, sleepRequest, forceNormal;
  logic        enterSleep, enterStandby;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdata;
  logic [3:0]  peakNegative;
  logic [8:0]  snrRaw, sqTab [5];
  logic [7:0]  sqiRaw;
  logic [31:0] sqExp [5];
  int          miscompares, nTests;

  pmld_regs i_pmld_regs (.*);

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", nTests, miscompares);
    if (miscompares == 0 && nTests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    nTests++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: word %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    nTests++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: flag %b expected %b", $time, got, exp);
    end
  endtask

  // one transfer; the slave never stretches access, but pready is still polled
  task automatic apb(input logic wr, input logic [9:0] idx, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= {idx, 2'h0};
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 8);
    rdata = prdata;
    rerr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    #1;
    if (pready !== 1'b1) begin
      miscompares++;
      complete_run;
    end
  endtask

  task automatic rd(input logic [9:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 32'h0);
    chk32(rdata, exp);
  endtask

  task automatic pulse(input logic neg);
    @(posedge clk);
    sleepNegotiated <= neg;
    standbyToNormal <= !neg;
    @(posedge clk);
    sleepNegotiated <= 1'b0;
    standbyToNormal <= 1'b0;
    #1;
  endtask

  // strap only moves while reset is held, so it is stable at capture
  task automatic do_reset(input logic strap);
    @(posedge clk);
    rst             <= 1'h1;
    strapAutonomous <= strap;
    repeat (20) @(posedge clk);
    rst <= 1'h0;
    repeat (5) @(posedge clk);
    #1;
  endtask

  task automatic t_reset_values;
    chk1(autonomousMode, 1'b1);
    rd(`PMLD_IDX_AUTO, 32'h0000005A);
    rd(`PMLD_IDX_AUTO, 32'h0000001A);
    rd(`PMLD_IDX_PWR_CMD, 32'h00000000);
    chk1(sendSleepCodegroups, 1'b0);
  endtask

  task automatic t_codegroups;
    apb(1'b1, `PMLD_IDX_AUTO, 32'h00000059);
    rd(`PMLD_IDX_AUTO, 32'h00000019);
    chk1(autonomousMode, 1'b1);
    chk1(sleepCodegroupPermit, 1'b1);
    apb(1'b1, `PMLD_IDX_PWR_CMD, 32'hFFFF0002);
    chk1(sendSleepCodegroups, 1'b1);
    rd(`PMLD_IDX_PWR_CMD, 32'h00000002);
    apb(1'b1, `PMLD_IDX_AUTO, 32'h00000018);
    chk1(sendSleepCodegroups, 1'b0);
    chk1(sleepRequest, 1'b1);
    apb(1'b1, `PMLD_IDX_PWR_CMD, 32'h00000000);
  endtask

  task automatic t_sleep_select;
    pulse(1'b1);
    chk1(enterStandby, 1'b1);
    chk1(enterSleep, 1'b0);
    apb(1'b1, `PMLD_IDX_AUTO, 32'h0000001A);
    pulse(1'b1);
    chk1(enterSleep, 1'b1);
    chk1(enterStandby, 1'b0);
  endtask

  task automatic t_force_normal;
    apb(1'b1, `PMLD_IDX_PWR_CMD, 32'h00000001);
    chk1(forceNormal, 1'b1);
    pulse(1'b1);
    chk1(forceNormal, 1'b1);
    pulse(1'b0);
    chk1(forceNormal, 1'b0);
  endtask

  task automatic t_results;
    @(posedge clk);
    peakNegative <= 4'hA;
    snrRaw       <= 9'h1FF;
    linkUp       <= 1'b1;
    apb(1'b1, `PMLD_IDX_PEAK, 32'hFFFFFFFF);
    // all four polarity bits read back as driven on peakNegative; no validity qualification
    rd(`PMLD_IDX_PEAK, 32'h00005000);
    // ratio read only while the link is up
    rd(`PMLD_IDX_SNR, 32'h000001FF);
    for (int i = 0; i < 5; i++) begin
      @(posedge clk);
      {linkUp, sqiRaw} <= sqTab[i];
      repeat (3) @(posedge clk);
      rd(`PMLD_IDX_SQI, sqExp[i]);
    end
    apb(1'b0, 10'h100, 32'h0);
    chk1(rerr, 1'b1);
    chk32(rdata, 32'h0);
  endtask

  task automatic t_managed;
    do_reset(1'b0);
    chk1(autonomousMode, 1'b0);
    rd(`PMLD_IDX_AUTO, 32'h0000001A);
    apb(1'b1, `PMLD_IDX_AUTO, 32'h0000005A);
    chk1(autonomousMode, 1'b0);
  endtask

  initial begin
    {rst, strapAutonomous} = 2'h3;
    {psel, penable, pwrite, linkUp, sleepNegotiated, standbyToNormal} = 6'h0;
    paddr = 12'h0;
    pwdata = 32'h0;
    peakNegative = 4'h0;
    snrRaw = 9'h0;
    sqiRaw = 8'h0;
    sqTab = '{9'h147, 9'h146, 9'h128, 9'h127, 9'h050};
    sqExp = '{32'h347, 32'h246, 32'h228, 32'h127, 32'h050};
    miscompares = 0;
    nTests = 0;
    do_reset(1'b1);
    t_reset_values;
    t_codegroups;
    t_sleep_select;
    t_force_normal;
    t_results;
    t_managed;
    complete_run;
  end
endmodule

`default_nettype wire
